// File: core/sdp_cfg.svh
// Purpose: constants of the divider program port
// Assumes: included by bare name
// Notes: offsets are byte addresses on the register bus
`ifndef SDP_CFG_SVH
`define SDP_CFG_SVH

`define SDP_FB_W 9
`define SDP_OD_W 3
`define SDP_DS_W 2
`define SDP_SW_W 17
`define SDP_SW_FB_LSB 8
`define SDP_SW_A_LSB 5
`define SDP_SW_B_LSB 2
`define SDP_SW_DS_LSB 0
`define SDP_PIN_W 22

`define SDP_OFF_CTRL 32'h0000_0000
`define SDP_OFF_STATUS 32'h0000_0004
`define SDP_OFF_VALUES 32'h0000_0008
`define SDP_OFF_SHIFT 32'h0000_000C
`define SDP_CTRL_RESET 32'h0000_0001
`define SDP_CTRL_RUN_BIT 0

`endif

// File: core/sdp_pkg.sv
// Purpose: types of the divider program port
// Assumes: nothing
// Notes: load state codes are all legal
package sdp_pkg;
  typedef enum logic [1:0] {
    ST_PAR_LIVE = 2'b00,
    ST_PAR_HELD = 2'b01,
    ST_SER_HELD = 2'b10,
    ST_SER_PASS = 2'b11
  } sdp_load_st_t;
  typedef logic [1:0] sdp_htrans_t;
endpackage

// File: core/sdp_div_if.sv
// Purpose: carrier between the top and one output divider
// Assumes: one instance per output pair
// Notes: ratio field is the raw three-bit setting
`timescale 1ns/1ps
interface sdp_div_if;
  logic [2:0] ratio;
  logic run;
  logic clk_out;
  modport ctl (output ratio, output run, input clk_out);
  modport div (input ratio, input run, output clk_out);
endinterface

// File: core/sdp_out_div.sv
// Purpose: one output divider with even ratio and 50% duty
// Assumes: hclk stands in for the vco
// Notes: half period is ratio plus one clocks
`timescale 1ns/1ps
module sdp_out_div (
  input wire logic hclk,
  input wire logic hresetn,
  sdp_div_if.div dv
);
  logic [3:0] cnt_q;
  logic out_q;
  logic [3:0] half;
  logic [3:0] hi_len_q;
  logic [2:0] ratio_q;
  logic steady_q;

  assign half = {1'b0, dv.ratio} + 4'h1;
  assign dv.clk_out = out_q;

  // toggle every half period for an even duty
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 4'h0;
      out_q <= 1'b0;
    end else if (!dv.run) begin
      cnt_q <= 4'h0;
      out_q <= 1'b0;
    end else if (cnt_q >= half - 4'h1) begin
      cnt_q <= 4'h0;
      out_q <= ~out_q;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // high phase length, and whether the ratio held still across it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_len_q <= 4'h0;
      ratio_q <= 3'h0;
      steady_q <= 1'b0;
    end else begin
      ratio_q <= dv.ratio;
      steady_q <= (!out_q || steady_q) && (dv.ratio == ratio_q);
      if (!out_q) begin
        hi_len_q <= 4'h0;
      end else if (hi_len_q != 4'hF) begin
        hi_len_q <= hi_len_q + 4'h1;
      end
    end
  end

  a_high_half: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(out_q) && $past(dv.run) && $stable(dv.ratio) && steady_q |-> hi_len_q == half)
    else $error("divider high phase not equal to half period");
endmodule

// File: core/sdp_top.sv
// Purpose: program port loading feedback and output dividers
// Assumes: pins come from outside hclk domain; hclk stands in for the vco
// Notes: registers over ahb-lite, zero wait states
// Notes on behaviour
// - parallel load low passes parallel values straight to the dividers
// - parallel load rising latches values until it falls or serial loads
// - parallel mode forces the diagnostic output low
// - serial mode shifts data in on each shift clock rise
// - load strobe rising moves shift register into the dividers
// - load strobe falling latches the transferred values
// - strobe held high passes shifted data on every shift clock rise
// - serial word holds feedback, both output fields, diagnostic select
// - diagnostic select picks low, shift out, feedback or synth output
// - each output divider gives a 50% duty output
// - each output pair has its own independent divider setting
// - feedback value is a nine-bit field
// - reference copy output is switchable and off by default
// - master reset holds dividers, true outputs low, inverted high
// - master reset leaves loaded values untouched
// - reference copy driven only while its enable is high
`timescale 1ns/1ps
`include "sdp_cfg.svh"
module sdp_top #(
  parameter int FB_LSB = `SDP_SW_FB_LSB,
  parameter int A_LSB = `SDP_SW_A_LSB,
  parameter int B_LSB = `SDP_SW_B_LSB,
  parameter int DS_LSB = `SDP_SW_DS_LSB
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire sdp_pkg::sdp_htrans_t htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic parallel_load_n,
  input wire logic [`SDP_FB_W-1:0] feedback_divider_value,
  input wire logic [`SDP_OD_W-1:0] output_divider_a_value,
  input wire logic [`SDP_OD_W-1:0] output_divider_b_value,
  input wire logic serial_shift_clock,
  input wire logic serial_data_in,
  input wire logic serial_load_strobe,
  input wire logic master_reset,
  input wire logic refout_enable,
  input wire logic ref_clk_in,
  output logic synth_out_true_a,
  output logic synth_out_inverted_a,
  output logic synth_out_true_b,
  output logic synth_out_inverted_b,
  output logic diagnostic_out,
  output logic reference_copy_out,
  output logic reference_copy_oe
);
  import sdp_pkg::*;

  localparam int PW = `SDP_PIN_W;
  localparam int SW = `SDP_SW_W;

  logic [PW-1:0] pin_raw, s1_q, s2_q, s3_q, flt_q;
  logic pl_n_f, sclk_f, sdata_f, sload_f, mreset_f, refen_f, refclk_f;
  logic [`SDP_FB_W-1:0] par_fb_f;
  logic [`SDP_OD_W-1:0] par_a_f, par_b_f;
  logic sclk_prev_q, sload_prev_q;
  logic sclk_rise, sload_rise, sload_fall;
  sdp_load_st_t st_q;
  logic [SW-1:0] sr_q, sr_nx;
  logic [`SDP_FB_W-1:0] fb_q;
  logic [`SDP_OD_W-1:0] div_a_q, div_b_q;
  logic [`SDP_DS_W-1:0] ds_q;
  logic [`SDP_FB_W-1:0] fb_cnt_q;
  logic fb_div_q;
  logic ctrl_run_q;
  logic diag_q, refout_q, refoe_q;
  logic div_run;
  logic ap_valid;
  logic wr_q;
  logic [31:0] waddr_q;
  logic [31:0] rd_mux;
  logic [`SDP_OD_W-1:0] sel_ratio [2];
  logic synth_clk [2];

  // input synchronisers, three stages and an agreement filter
  assign pin_raw = {parallel_load_n, serial_shift_clock, serial_data_in,
                    serial_load_strobe, master_reset, refout_enable, ref_clk_in,
                    feedback_divider_value, output_divider_a_value,
                    output_divider_b_value};

  for (genvar gi = 0; gi < PW; gi++) begin : g_sync
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        s1_q[gi] <= 1'b0;
        s2_q[gi] <= 1'b0;
        s3_q[gi] <= 1'b0;
        flt_q[gi] <= 1'b0;
      end else begin
        s1_q[gi] <= pin_raw[gi];
        s2_q[gi] <= s1_q[gi];
        s3_q[gi] <= s2_q[gi];
        if (s2_q[gi] == s3_q[gi]) begin
          flt_q[gi] <= s3_q[gi];
        end
      end
    end
  end

  assign {pl_n_f, sclk_f, sdata_f, sload_f, mreset_f, refen_f, refclk_f,
          par_fb_f, par_a_f, par_b_f} = flt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_prev_q <= 1'b0;
      sload_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_f;
      sload_prev_q <= sload_f;
    end
  end

  assign sclk_rise = sclk_f && !sclk_prev_q;
  assign sload_rise = sload_f && !sload_prev_q;
  assign sload_fall = !sload_f && sload_prev_q;

  // shift register, serial word layout
  assign sr_nx = {sr_q[SW-2:0], sdata_f};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sr_q <= '0;
    end else if (pl_n_f && sclk_rise) begin
      sr_q <= sr_nx;
    end
  end

  // load state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= ST_PAR_LIVE;
    end else if (!pl_n_f) begin
      st_q <= ST_PAR_LIVE;
    end else begin
      unique case (st_q)
        ST_PAR_LIVE: begin
          st_q <= sload_rise ? ST_SER_PASS : ST_PAR_HELD;
        end
        ST_PAR_HELD, ST_SER_HELD: begin
          if (sload_rise) begin
            st_q <= ST_SER_PASS;
          end
        end
        ST_SER_PASS: begin
          if (sload_fall) begin
            st_q <= ST_SER_HELD;
          end
        end
      endcase
    end
  end

  // divider values; master reset never touches them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fb_q <= '0;
      div_a_q <= '0;
      div_b_q <= '0;
    end else if (!pl_n_f) begin
      fb_q <= par_fb_f;
      div_a_q <= par_a_f;
      div_b_q <= par_b_f;
    end else if (st_q != ST_SER_PASS && sload_rise) begin
      fb_q <= sr_q[FB_LSB +: `SDP_FB_W];
      div_a_q <= sr_q[A_LSB +: `SDP_OD_W];
      div_b_q <= sr_q[B_LSB +: `SDP_OD_W];
    end else if (st_q == ST_SER_PASS && sclk_rise) begin
      fb_q <= sr_nx[FB_LSB +: `SDP_FB_W];
      div_a_q <= sr_nx[A_LSB +: `SDP_OD_W];
      div_b_q <= sr_nx[B_LSB +: `SDP_OD_W];
    end
  end

  // diagnostic select is set only by serial loading
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ds_q <= '0;
    end else if (pl_n_f && st_q != ST_SER_PASS && sload_rise) begin
      ds_q <= sr_q[DS_LSB +: `SDP_DS_W];
    end else if (pl_n_f && st_q == ST_SER_PASS && sclk_rise) begin
      ds_q <= sr_nx[DS_LSB +: `SDP_DS_W];
    end
  end

  // dividers run unless held by master reset or software
  assign div_run = ctrl_run_q && !mreset_f;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fb_cnt_q <= '0;
      fb_div_q <= 1'b0;
    end else if (!div_run) begin
      fb_cnt_q <= '0;
      fb_div_q <= 1'b0;
    end else if (fb_cnt_q + 9'h001 >= fb_q) begin
      fb_cnt_q <= '0;
      fb_div_q <= ~fb_div_q;
    end else begin
      fb_cnt_q <= fb_cnt_q + 9'h001;
    end
  end

  // one independent divider per output pair
  assign sel_ratio[0] = div_a_q;
  assign sel_ratio[1] = div_b_q;

  for (genvar gd = 0; gd < 2; gd++) begin : g_out
    sdp_div_if dif ();
    assign dif.ratio = sel_ratio[gd];
    assign dif.run = div_run;
    assign synth_clk[gd] = dif.clk_out;
    sdp_out_div u_div (
      .hclk(hclk),
      .hresetn(hresetn),
      .dv(dif)
    );
  end

  assign synth_out_true_a = synth_clk[0];
  assign synth_out_inverted_a = ~synth_clk[0];
  assign synth_out_true_b = synth_clk[1];
  assign synth_out_inverted_b = ~synth_clk[1];

  // diagnostic output source
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      diag_q <= 1'b0;
    end else if (st_q == ST_PAR_LIVE || st_q == ST_PAR_HELD) begin
      diag_q <= 1'b0;
    end else begin
      unique case (ds_q)
        2'b00: diag_q <= 1'b0;
        2'b01: diag_q <= sr_q[SW-1];
        2'b10: diag_q <= fb_div_q;
        2'b11: diag_q <= synth_clk[0];
      endcase
    end
  end

  assign diagnostic_out = diag_q;

  // reference copy, off after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      refout_q <= 1'b0;
      refoe_q <= 1'b0;
    end else begin
      refout_q <= refclk_f & refen_f;
      refoe_q <= refen_f;
    end
  end

  assign reference_copy_out = refout_q;
  assign reference_copy_oe = refoe_q;

  // ahb-lite slave
  assign ap_valid = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr)
      `SDP_OFF_CTRL: rd_mux = {31'h0000_0000, ctrl_run_q};
      `SDP_OFF_STATUS: rd_mux = {24'h00_0000, ds_q, st_q, diag_q, refoe_q,
                                 mreset_f, pl_n_f};
      `SDP_OFF_VALUES: rd_mux = {17'h0_0000, div_b_q, div_a_q, fb_q};
      `SDP_OFF_SHIFT: rd_mux = {15'h0000, sr_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      waddr_q <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
    end else begin
      if (hready) begin
        wr_q <= ap_valid && hwrite;
        waddr_q <= haddr;
      end
      if (ap_valid && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_run_q <= 1'(`SDP_CTRL_RESET);
    end else if (wr_q && waddr_q == `SDP_OFF_CTRL) begin
      ctrl_run_q <= hwdata[`SDP_CTRL_RUN_BIT];
    end
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_par_pass: assert property (!pl_n_f [*2] |-> fb_q == $past(par_fb_f))
    else $error("parallel value not passed through");
  a_par_hold: assert property ((st_q == ST_PAR_HELD) && pl_n_f && !sload_rise |=>
    $stable(fb_q) && $stable(div_a_q))
    else $error("parallel value changed while held");
  a_diag_par: assert property (st_q == ST_PAR_LIVE ##1 1'b1 |-> !diag_q)
    else $error("diagnostic output not low in parallel mode");
  a_shift_in: assert property (pl_n_f && sclk_rise |=>
    sr_q == {$past(sr_q[SW-2:0]), $past(sdata_f)})
    else $error("shift register did not take serial bit");
  a_ser_xfer: assert property (pl_n_f && sload_rise && st_q != ST_SER_PASS |=>
    fb_q == $past(sr_q[FB_LSB +: `SDP_FB_W]) && ds_q == $past(sr_q[DS_LSB +: 2]))
    else $error("strobe rise did not transfer the word");
  a_ser_latch: assert property (st_q == ST_SER_HELD && pl_n_f && !sload_rise |=>
    $stable(fb_q) && $stable(div_b_q) && $stable(ds_q))
    else $error("latched serial value changed");
  a_pass_edge: assert property (pl_n_f && st_q == ST_SER_PASS && sclk_rise |=>
    div_a_q == $past(sr_nx[A_LSB +: `SDP_OD_W]))
    else $error("held strobe did not pass data");
  a_reset_outs: assert property (mreset_f ##1 mreset_f |->
    !synth_out_true_a && synth_out_inverted_a && !synth_out_true_b && synth_out_inverted_b)
    else $error("outputs not held under master reset");
  a_reset_keep: assert property (mreset_f && pl_n_f && !sload_rise && !sclk_rise |=>
    $stable(fb_q))
    else $error("master reset disturbed loaded value");
  a_diag_fb: assert property (ds_q == 2'b10 && st_q[1] |=> diag_q == $past(fb_div_q))
    else $error("diagnostic select did not pick feedback output");
  a_ref_oe: assert property (refen_f ##1 refen_f |-> reference_copy_oe)
    else $error("reference copy not enabled");
  a_ref_off: assert property (!refen_f ##1 !refen_f |-> !reference_copy_oe)
    else $error("reference copy driven while disabled");

  c_ser_xfer: cover property (pl_n_f && sload_rise ##[1:200] sload_fall);
  c_pass_mode: cover property (st_q == ST_SER_PASS && sclk_rise);
  c_diag_synth: cover property (ds_q == 2'b11 && st_q == ST_SER_HELD);
endmodule

// File: bench/sdp_ctl_model.sv
// Purpose: board controller driving the parallel and serial load pins
// Assumes: pins are asynchronous to hclk; shift clock period 125 ns
// Notes: released serial data falls to its pulldown level
`timescale 1ns/1ps
`include "sdp_cfg.svh"
module sdp_ctl_model (
  output logic parallel_load_n,
  output logic [`SDP_FB_W-1:0] feedback_divider_value,
  output logic [`SDP_OD_W-1:0] output_divider_a_value,
  output logic [`SDP_OD_W-1:0] output_divider_b_value,
  output logic serial_shift_clock,
  output logic serial_data_in,
  output logic serial_load_strobe
);
  initial begin
    parallel_load_n = 1'b0;
    feedback_divider_value = 9'h017;
    output_divider_a_value = 3'h0;
    output_divider_b_value = 3'h0;
    serial_shift_clock = 1'b0;
    serial_data_in = 1'b0;
    serial_load_strobe = 1'b0;
  end

  // drive the parallel strapping values
  task automatic par(input logic [8:0] f, input logic [2:0] a, input logic [2:0] b);
    feedback_divider_value = (f < 9'd23 || f > 9'd30) ? 9'd23 : f;
    output_divider_a_value = a;
    output_divider_b_value = b;
    #50;
  endtask

  task automatic pload(input logic v);
    #50;
    parallel_load_n = v;
    #50;
  endtask

  // msb first, data held across the whole shift clock period
  task automatic shift(input logic [16:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in = w[i];
      #62.5;
      serial_shift_clock = 1'b1;
      #62.5;
      serial_shift_clock = 1'b0;
    end
    serial_data_in = 1'b0;
  endtask

  task automatic strobe(input logic v);
    #62.5;
    serial_load_strobe = v;
    #62.5;
  endtask
endmodule

// File: bench/sdp_top_tb.sv
// Purpose: self-checking bench of the divider program port
// Assumes: register reads land in the data phase after a zero-wait address phase
// Notes: outputs counted over windows that span whole divider periods
`timescale 1ns/1ps
`include "sdp_cfg.svh"
module sdp_top_tb;
  import sdp_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_v;
  logic master_reset, refout_enable, diagnostic_out, reference_copy_out, reference_copy_oe;
  logic synth_out_true_a, synth_out_inverted_a, synth_out_true_b, synth_out_inverted_b;
  logic [31:0] haddr, hwdata, hrdata;
  logic [2:0] hsize;
  sdp_htrans_t htrans;
  logic parallel_load_n, serial_shift_clock, serial_data_in, serial_load_strobe;
  logic [8:0] feedback_divider_value;
  logic [2:0] output_divider_a_value, output_divider_b_value;
  logic [2:0] rc = 3'h0;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  integer ha, hb, ia, ib, hd, ro;
  int err_count = 0;
  int checked = 0;
  integer seed = 32'hff4a;

  sdp_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .parallel_load_n(parallel_load_n),
    .feedback_divider_value(feedback_divider_value),
    .output_divider_a_value(output_divider_a_value),
    .output_divider_b_value(output_divider_b_value), .serial_shift_clock(serial_shift_clock),
    .serial_data_in(serial_data_in), .serial_load_strobe(serial_load_strobe),
    .master_reset(master_reset), .refout_enable(refout_enable), .ref_clk_in(rc[2]),
    .synth_out_true_a(synth_out_true_a), .synth_out_inverted_a(synth_out_inverted_a),
    .synth_out_true_b(synth_out_true_b), .synth_out_inverted_b(synth_out_inverted_b),
    .diagnostic_out(diagnostic_out), .reference_copy_out(reference_copy_out),
    .reference_copy_oe(reference_copy_oe));

  sdp_ctl_model pm (.parallel_load_n(parallel_load_n),
    .feedback_divider_value(feedback_divider_value),
    .output_divider_a_value(output_divider_a_value),
    .output_divider_b_value(output_divider_b_value), .serial_shift_clock(serial_shift_clock),
    .serial_data_in(serial_data_in), .serial_load_strobe(serial_load_strobe));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  always @(posedge hclk) rc <= rc + 3'h1;

  task automatic end_sim;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= 1'b1;
    hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'($random(seed));
    hwrite <= 1'($random(seed));
    hsize <= 3'($random(seed));
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= 1'b0;
    hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'($random(seed));
    hwrite <= 1'($random(seed));
    hsize <= 3'($random(seed));
    htrans <= 2'b00;
    eq.push_back(e & m);
    mq.push_back(m);
    rd_v <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_v <= 1'b0;
  endtask

  always @(posedge hclk) begin
    if (rd_v === 1'b1) begin
      cmp(eq.pop_front(), hrdata & mq.pop_front());
      cmp(32'h0000_0000, 32'(hresp));
    end
  end

  task automatic settle;
    repeat (10) @(posedge hclk);
  endtask

  task automatic win(input int n);
    {ha, hb, ia, ib, hd, ro} = '0;
    repeat (n) begin
      @(posedge hclk);
      ha += synth_out_true_a;
      hb += synth_out_true_b;
      ia += synth_out_inverted_a;
      ib += synth_out_inverted_b;
      hd += diagnostic_out;
      ro += reference_copy_out;
    end
  endtask

  function automatic logic [31:0] val(input logic [8:0] f, input logic [2:0] a, input logic [2:0] b);
    return {17'h0_0000, b, a, f};
  endfunction

  initial begin
    #200_000;
    err_count++;
    end_sim;
  end

  initial begin
    int n;
    logic [8:0] f, f2;
    logic [2:0] a, b, a2, b2;
    {hsel, hwrite, master_reset, refout_enable, rd_v, hresetn} = '0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'b00;
    hsize = 3'b010;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`SDP_OFF_CTRL, `SDP_CTRL_RESET, 32'hFFFF_FFFF);
    rd(`SDP_OFF_VALUES, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(32'h0000_0010, 32'h0000_0000, 32'hFFFF_FFFF);
    cmp(32'h0000_0000, 32'(reference_copy_oe));
    wr(`SDP_OFF_CTRL, 32'h0000_0000);
    rd(`SDP_OFF_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(`SDP_OFF_CTRL, 32'h0000_0001);
    f = 9'd23 + 9'($random(seed) & 7);
    a = 3'($random(seed));
    b = 3'($random(seed));
    f2 = 9'd23 + 9'($random(seed) & 7);
    a2 = 3'($random(seed));
    b2 = 3'($random(seed));
    pm.par(f, a, b);
    settle;
    rd(`SDP_OFF_VALUES, val(f, a, b), 32'hFFFF_FFFF);
    rd(`SDP_OFF_STATUS, 32'h0000_0000, 32'h0000_0008);
    n = 4 * (a + 1) * (b + 1);
    win(n);
    cmp(n / 2, ha);
    cmp(n / 2, hb);
    pm.pload(1'b1);
    pm.par(f2, a2, b2);
    settle;
    rd(`SDP_OFF_VALUES, val(f, a, b), 32'hFFFF_FFFF);
    pm.shift({f2, a2, b2, 2'b00}, 17);
    settle;
    rd(`SDP_OFF_SHIFT, {15'h0000, f2, a2, b2, 2'b00}, 32'hFFFF_FFFF);
    rd(`SDP_OFF_VALUES, val(f, a, b), 32'hFFFF_FFFF);
    pm.strobe(1'b1);
    settle;
    rd(`SDP_OFF_VALUES, val(f2, a2, b2), 32'hFFFF_FFFF);
    pm.strobe(1'b0);
    pm.shift({f, a, b, 2'b11}, 17);
    settle;
    rd(`SDP_OFF_VALUES, val(f2, a2, b2), 32'hFFFF_FFFF);
    for (int ds = 0; ds < 4; ds++) begin
      pm.shift({f2, a2, b2, 2'(ds)}, 17);
      pm.strobe(1'b1);
      pm.strobe(1'b0);
      settle;
      rd(`SDP_OFF_STATUS, 32'(ds << 6), 32'h0000_00C0);
      n = (ds == 2) ? 8 * f2 : 4 * (a2 + 1) * (b2 + 1);
      win(n);
      cmp((ds >= 2) ? n / 2 : 0, hd);
    end
    pm.strobe(1'b1);
    pm.shift({f, a, b, 2'b11}, 17);
    settle;
    rd(`SDP_OFF_VALUES, val(f, a, b), 32'hFFFF_FFFF);
    pm.strobe(1'b0);
    master_reset <= 1'b1;
    settle;
    win(24);
    cmp(0, ha + hb);
    cmp(24, ia);
    cmp(24, ib);
    rd(`SDP_OFF_VALUES, val(f, a, b), 32'hFFFF_FFFF);
    rd(`SDP_OFF_STATUS, 32'h0000_00C0, 32'h0000_00C0);
    master_reset <= 1'b0;
    settle;
    n = 4 * (a + 1) * (b + 1);
    win(n);
    cmp(n / 2, ha);
    cmp(n, hb + ib);
    refout_enable <= 1'b1;
    settle;
    cmp(32'h0000_0001, 32'(reference_copy_oe));
    win(64);
    cmp(32, ro);
    refout_enable <= 1'b0;
    settle;
    cmp(32'h0000_0000, 32'(reference_copy_oe));
    pm.pload(1'b0);
    settle;
    win(40);
    cmp(0, hd);
    wr(`SDP_OFF_CTRL, 32'h0000_0000);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`SDP_OFF_CTRL, `SDP_CTRL_RESET, 32'hFFFF_FFFF);
    rd(`SDP_OFF_STATUS, 32'h0000_0000, 32'h0000_00CC);
    settle;
    rd(`SDP_OFF_VALUES, val(f2, a2, b2), 32'hFFFF_FFFF);
    end_sim;
  end
endmodule
